/* motion_pkg.sv */
/*
  Shared constants and carriers for the motion-event, offset and autosleep block.
  Assumes a single 25 MHz core clock and an external serial front end.
*/
package motion_pkg;
  localparam logic [7:0] ADDR_X_OFS      = 8'h1E;
  localparam logic [7:0] ADDR_Y_OFS      = 8'h1F;
  localparam logic [7:0] ADDR_Z_OFS      = 8'h20;
  localparam logic [7:0] ADDR_TAP_AXES   = 8'h2A;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h2B;
  localparam logic [7:0] ADDR_RATE_PWR   = 8'h2C;
  localparam logic [7:0] ADDR_INT_SRC    = 8'h30;

  localparam logic [7:0] OFS_RESET       = 8'h00;
  localparam logic [7:0] TAP_AXES_RESET  = 8'h00;
  localparam logic [7:0] RATE_PWR_RESET  = 8'h0A;
  localparam int         TAP_IMPROVED_BIT = 4;
  localparam int         TAP_SUPPRESS_BIT = 3;
  localparam int         ASLEEP_BIT      = 3;
  localparam int         TAP_SRC_BIT     = 6;
  localparam int         DTAP_SRC_BIT    = 5;
  localparam int         ACT_SRC_BIT     = 4;
  localparam int         INACT_SRC_BIT   = 3;
  localparam int         FF_SRC_BIT      = 2;
  localparam int         OFS_SHIFT       = 2;
  localparam int         RATE_W          = 4;
  localparam logic [3:0] SLEEP_RATE      = 4'h3;
  localparam int         SAMPLE_W        = 13;

  typedef struct packed {
    logic [SAMPLE_W-1:0] x;
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] z;
  } axes_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {
    LINK_SEEK_INACT = 2'b00,
    LINK_SEEK_ACT   = 2'b01
  } link_e;
endpackage

/* motion_event_offset_autosleep.sv */
/*
  Motion events, link/autosleep sequencing and per-axis offset correction.
  Assumes the serial front end delivers one-cycle register requests on this clock,
  and that raw samples and detector hits arrive synchronous to i_clk.
*/
`timescale 1ns/1ns
// What this block does
// - Improved-tap bit in tap axis config selects the improved tap algorithm.
// - Improved taps use filtered decimated data with ac-coupled difference.
// - Negative acceleration at tap gives negative sign; opposite face gives positive.
// - Lower output rates come from decimating one common sample stream.
// - Activity, free-fall and normal tap use undecimated samples.
// - Link mode arms activity only after inactivity was seen.
// - Reading interrupt source clears pending activity and inactivity.
// - No autosleep while an activity interrupt is still pending.
// - Asleep status bit reflects the sleep state.
// - Low power mode keeps data-ready working; sleep need not.
// - Sleep, autosleep and link together drop to low rate on inactivity.
// - On inactivity in link mode, disable inactivity and enable activity.
// - Activity while auto-asleep restores the configured rate and raises interrupt.
// - After activity in link mode, disable activity and re-enable inactivity.
// - Add signed 8-bit axis offset to every sample before output.
// - Offset step is fixed, rescaled to the output scale.
// - Full-resolution output uses offset shifted left by two.
// - Offset registers reset to zero.
// - Double tap only when latency and window are both nonzero.
// - Event status is never cleared by reading, only overwritten by new tap.
module motion_event_offset_autosleep #(
  parameter int DECIM_W = 10
) (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_resetn,
  // Register access
  input  wire motion_pkg::reg_req_s      i_req,
  output logic [7:0]                     o_rdata,
  // Raw samples at the internal rate
  input  wire logic                      i_sample_vld,
  input  wire motion_pkg::axes_s         i_sample,
  input  wire logic                      i_full_res,
  input  wire logic [1:0]                i_range,
  // Detector hits
  input  wire logic                      i_act_hit,
  input  wire logic                      i_inact_hit,
  input  wire logic                      i_ff_hit,
  input  wire logic                      i_tap_raw_hit,
  input  wire logic                      i_tap_filt_hit,
  input  wire logic                      i_dtap_hit,
  input  wire logic [2:0]                i_tap_axis,
  input  wire logic [2:0]                i_tap_neg,
  input  wire logic                      i_dtap_timing_ok,
  // Mode controls
  input  wire logic                      i_link,
  input  wire logic                      i_auto_sleep,
  input  wire logic                      i_sleep,
  // Results
  output motion_pkg::axes_s              o_data,
  output logic                           o_data_vld,
  output logic [3:0]                     o_active_rate,
  output logic                           o_asleep,
  output logic                           o_act_armed,
  output logic                           o_inact_armed,
  output logic                           o_tap_improved,
  output logic [2:0]                     o_tap_sign
);
  import motion_pkg::*;

  logic [7:0]         ofs_ff [3];
  logic [7:0]         tap_axes_ff;
  logic [7:0]         rate_pwr_ff;
  logic [7:0]         status_ff;
  logic [7:0]         src_ff;
  logic               asleep_ff;
  link_e              link_ff;
  logic [DECIM_W-1:0] decim_ff;
  logic               data_vld_ff;
  logic [7:0]         rdata_ff;
  logic [2:0]         sign_ff;

  function automatic logic [SAMPLE_W-1:0] add_sat(input logic [SAMPLE_W-1:0] s, input logic [7:0] o,
                                                   input logic fr, input logic [1:0] rng);
    logic signed [SAMPLE_W+1:0] sum;
    logic signed [SAMPLE_W+1:0] ofs;
    logic signed [SAMPLE_W+1:0] hi;
    sum = '0;
    ofs = '0;
    hi  = '0;
    if (fr) begin
      ofs = (SAMPLE_W+2)'($signed(o)) <<< OFS_SHIFT;
    end else begin
      ofs = ((SAMPLE_W+2)'($signed(o)) <<< OFS_SHIFT) >>> rng;
    end
    sum = (SAMPLE_W+2)'($signed(s)) + ofs;
    hi  = (SAMPLE_W+2)'((1 << (SAMPLE_W-1)) - 1);
    if (sum > hi) begin
      add_sat = {1'b0, {(SAMPLE_W-1){1'b1}}};
    end else if (sum < -hi - 1) begin
      add_sat = {1'b1, {(SAMPLE_W-1){1'b0}}};
    end else begin
      add_sat = sum[SAMPLE_W-1:0];
    end
  endfunction

  // Rate decimation from one stream; divide by the lesser of 2^(max-rate) and 2^DECIM_W
  wire [3:0]  cfg_rate    = rate_pwr_ff[RATE_W-1:0];
  wire [3:0]  active_rate = asleep_ff ? SLEEP_RATE : cfg_rate;
  wire [3:0]  shift_amt   = 4'hF - active_rate;
  wire [DECIM_W-1:0] decim_mask = DECIM_W'((32'h1 << shift_amt) - 32'h1);
  wire        out_tick    = i_sample_vld && ((decim_ff & decim_mask) == '0);
  // Sleep without autosleep suppresses acquisition; low power keeps data-ready flowing
  wire        acq_tick    = out_tick && !(i_sleep && !i_auto_sleep);

  wire improved  = tap_axes_ff[TAP_IMPROVED_BIT];
  wire tap_hit   = improved ? (i_tap_filt_hit && out_tick) : i_tap_raw_hit;
  wire dtap_hit  = i_dtap_hit && i_dtap_timing_ok && tap_hit;
  wire act_en    = !i_link || (link_ff == LINK_SEEK_ACT);
  wire inact_en  = !i_link || (link_ff == LINK_SEEK_INACT);
  wire act_evt   = act_en && i_act_hit && i_sample_vld;
  wire inact_evt = inact_en && i_inact_hit;
  wire rd_src    = i_req.rd && (i_req.addr == ADDR_INT_SRC);
  // Pending activity blocks the automatic drop to low rate
  wire go_sleep  = inact_evt && i_link && i_auto_sleep && i_sleep && !src_ff[ACT_SRC_BIT];

  logic [7:0] nxt_src;
  always_comb begin
    nxt_src = rd_src ? 8'h00 : src_ff;
    if (act_evt) nxt_src[ACT_SRC_BIT] = 1'b1;
    if (inact_evt) nxt_src[INACT_SRC_BIT] = 1'b1;
    if (i_ff_hit && i_sample_vld) nxt_src[FF_SRC_BIT] = 1'b1;
    if (tap_hit) nxt_src[TAP_SRC_BIT] = 1'b1;
    if (dtap_hit) nxt_src[DTAP_SRC_BIT] = 1'b1;
  end

  wire [7:0] rd_mux =
    (i_req.addr == ADDR_X_OFS)      ? ofs_ff[0] :
    (i_req.addr == ADDR_Y_OFS)      ? ofs_ff[1] :
    (i_req.addr == ADDR_Z_OFS)      ? ofs_ff[2] :
    (i_req.addr == ADDR_TAP_AXES)   ? tap_axes_ff :
    (i_req.addr == ADDR_EVT_STATUS) ? {status_ff[7:4], asleep_ff, status_ff[2:0]} :
    (i_req.addr == ADDR_RATE_PWR)   ? rate_pwr_ff :
    (i_req.addr == ADDR_INT_SRC)    ? src_ff : 8'h00;

  // Decoded write strobes; status and source registers ignore writes
  wire wr_tap  = i_req.wr && (i_req.addr == ADDR_TAP_AXES);
  wire wr_rate = i_req.wr && (i_req.addr == ADDR_RATE_PWR);

  // Offsets sit at consecutive addresses, x first
  generate
    for (genvar g = 0; g < 3; g++) begin : gen_ofs
      wire wr_ofs = i_req.wr && (i_req.addr == ADDR_X_OFS + 8'(g));

      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          ofs_ff[g] <= OFS_RESET;
        end else if (wr_ofs) begin
          ofs_ff[g] <= i_req.wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tap_axes_ff <= TAP_AXES_RESET;
    end else if (wr_tap) begin
      tap_axes_ff <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rate_pwr_ff <= RATE_PWR_RESET;
    end else if (wr_rate) begin
      rate_pwr_ff <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      src_ff <= 8'h00;
    end else begin
      src_ff <= nxt_src;
    end
  end

  // Read data holds between reads so a slow host can pick it up late
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= 8'h00;
    end else if (i_req.rd) begin
      rdata_ff <= rd_mux;
    end
  end

  // Tap axis and sign stay until the next tap; reads never clear them
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_ff <= 8'h00;
      sign_ff   <= 3'b000;
    end else if (tap_hit) begin
      status_ff[2:0] <= i_tap_axis;
      sign_ff        <= i_tap_neg;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      link_ff <= LINK_SEEK_INACT;
    end else if (i_link && inact_evt) begin
      link_ff <= LINK_SEEK_ACT;
    end else if (i_link && act_evt) begin
      link_ff <= LINK_SEEK_INACT;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      asleep_ff <= 1'b0;
    end else if (go_sleep) begin
      asleep_ff <= 1'b1;
    end else if (act_evt || !i_auto_sleep) begin
      asleep_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      decim_ff <= '0;
    end else if (i_sample_vld) begin
      decim_ff <= decim_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      data_vld_ff <= 1'b0;
    end else begin
      data_vld_ff <= acq_tick;
    end
  end

  // Axis order follows the offset addresses: x, y, z
  logic [SAMPLE_W-1:0] raw_axis [3];
  logic [SAMPLE_W-1:0] corr_ff  [3];
  assign raw_axis[0] = i_sample.x;
  assign raw_axis[1] = i_sample.y;
  assign raw_axis[2] = i_sample.z;

  generate
    for (genvar a = 0; a < 3; a++) begin : gen_axis
      // Saturating add keeps a large trim from flipping the sign of the output
      wire [SAMPLE_W-1:0] corrected = add_sat(raw_axis[a], ofs_ff[a], i_full_res, i_range);

      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          corr_ff[a] <= '0;
        end else if (acq_tick) begin
          corr_ff[a] <= corrected;
        end
      end
    end
  endgenerate

  // Rate port and arm flags are registered copies to keep outputs flop-driven
  logic [3:0] rate_out_ff;
  logic       act_arm_ff;
  logic       inact_arm_ff;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rate_out_ff <= 4'h0;
    end else begin
      rate_out_ff <= active_rate;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      act_arm_ff <= 1'b0;
    end else begin
      act_arm_ff <= act_en;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      inact_arm_ff <= 1'b0;
    end else begin
      inact_arm_ff <= inact_en;
    end
  end

  assign o_rdata        = rdata_ff;
  assign o_data         = {corr_ff[0], corr_ff[1], corr_ff[2]};
  assign o_data_vld     = data_vld_ff;
  assign o_active_rate  = rate_out_ff;
  assign o_asleep       = asleep_ff;
  assign o_act_armed    = act_arm_ff;
  assign o_inact_armed  = inact_arm_ff;
  assign o_tap_improved = tap_axes_ff[TAP_IMPROVED_BIT];
  assign o_tap_sign     = sign_ff;
endmodule

/* motion_monitor.sv */
/* Port assertions for the motion block.
   Assumes one clock and the active-low asynchronous reset. */
`timescale 1ns/1ns
module motion_monitor import motion_pkg::*; #(parameter int DECIM_W = 10) (
  input wire logic       i_clk, i_resetn, i_sample_vld, i_act_hit, i_inact_hit, i_tap_raw_hit,
  input wire logic       i_tap_filt_hit, i_link, i_auto_sleep, i_sleep,
  input wire reg_req_s   i_req,
  input wire logic [2:0] i_tap_neg,
  input wire logic [7:0] o_rdata,
  input wire logic       o_data_vld, o_asleep, o_act_armed, o_inact_armed, o_tap_improved,
  input wire logic [3:0] o_active_rate,
  input wire logic [2:0] o_tap_sign
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  tap_cfg_a: assert property ((i_req.wr && i_req.addr == ADDR_TAP_AXES && i_req.wdata[TAP_IMPROVED_BIT])
    |=> ##[0:1] o_tap_improved) else $error("improved tap not set");
  tap_sign_a: assert property (($past(i_tap_raw_hit && !o_tap_improved) || (o_data_vld && $past(i_tap_filt_hit && o_tap_improved)))
    |-> o_tap_sign == $past(i_tap_neg)) else $error("tap sign wrong");
  sleep_entry_a: assert property ($rose(o_asleep) |-> $past(i_inact_hit && i_link && i_auto_sleep && i_sleep))
    else $error("sleep without cause");
  sleep_rate_a: assert property (o_asleep && $past(o_asleep) |-> o_active_rate == SLEEP_RATE)
    else $error("wrong rate asleep");
  wake_cause_a: assert property ($fell(o_asleep) && $past(i_sleep && i_auto_sleep) |-> $past(i_act_hit))
    else $error("wake without activity");
  act_arm_a: assert property ($rose(o_act_armed) && $past(i_link) |-> $past(i_inact_hit, 2))
    else $error("activity armed early");
  act_disarm_a: assert property ($past(i_link && o_act_armed && i_act_hit && i_sample_vld) |=> !o_act_armed && o_inact_armed)
    else $error("link swap missing");
  data_cause_a: assert property (o_data_vld |-> $past(i_sample_vld)) else $error("data without sample");
  rdata_hold_a: assert property (!$past(i_req.rd) |-> $stable(o_rdata)) else $error("read data moved");
endmodule
bind motion_event_offset_autosleep motion_monitor #(.DECIM_W(DECIM_W)) mon (.i_clk, .i_resetn, .i_req,
  .i_sample_vld, .i_act_hit, .i_inact_hit, .i_tap_raw_hit, .i_tap_filt_hit, .i_tap_neg, .i_link,
  .i_auto_sleep, .i_sleep, .o_rdata, .o_data_vld, .o_active_rate, .o_asleep, .o_act_armed,
  .o_inact_armed, .o_tap_improved, .o_tap_sign);

/* host_model.sv */
/* Host processor model issuing one-cycle register requests.
   Assumes read data is valid one cycle after the read edge. */
`timescale 1ns/1ns
module host_model import motion_pkg::*; (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output reg_req_s        o_req
);
  initial o_req = '0;
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_clk) #1 o_req = '{1'b1, 1'b0, a, d};
    @(posedge i_clk) #1 o_req = '0;
  endtask
  // Reading the source register is how pending events get serviced
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) #1 o_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_clk) #1 o_req = '0;
    d = i_rdata;
  endtask
endmodule

/* tb_top.sv */
/* Self-checking bench for the motion block.
   Assumes the host model owns the register requests. */
`timescale 1ns/1ns
module tb_top;
  import motion_pkg::*;
  logic        i_clk = 0, i_resetn = 0, i_sample_vld = 0, i_full_res = 1, i_act_hit = 0, i_inact_hit = 0;
  logic        i_ff_hit = 0, i_tap_raw_hit = 0, i_tap_filt_hit = 0, i_dtap_hit = 0, i_dtap_timing_ok = 0;
  logic        i_link = 0, i_auto_sleep = 0, i_sleep = 0, o_data_vld, o_asleep, o_act_armed, o_inact_armed;
  logic        o_tap_improved;
  logic [1:0]  i_range = 0;
  logic [2:0]  i_tap_axis = 3'h4, i_tap_neg = 0, o_tap_sign;
  logic [3:0]  o_active_rate;
  logic [7:0]  o_rdata, v, ofs [3];
  logic [31:0] seed = 32'h0000_001A, r;
  axes_s       i_sample = '0, o_data, s;
  reg_req_s    i_req;
  int          errors = 0, checked = 0, n;
  always #20 i_clk = ~i_clk;
  host_model host (.i_clk, .i_rdata(o_rdata), .o_req(i_req));
  motion_event_offset_autosleep uut (.i_clk, .i_resetn, .i_req, .o_rdata, .i_sample_vld, .i_sample,
    .i_full_res, .i_range, .i_act_hit, .i_inact_hit, .i_ff_hit, .i_tap_raw_hit, .i_tap_filt_hit,
    .i_dtap_hit, .i_tap_axis, .i_tap_neg, .i_dtap_timing_ok, .i_link, .i_auto_sleep, .i_sleep, .o_data,
    .o_data_vld, .o_active_rate, .o_asleep, .o_act_armed, .o_inact_armed, .o_tap_improved, .o_tap_sign);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Offset in steps of four LSBs, scaled down by range outside full resolution, then clipped
  function automatic logic [12:0] corr(input logic [12:0] x, input logic [7:0] o);
    logic signed [14:0] k, sum;
    k = $signed(o) <<< OFS_SHIFT;
    if (!i_full_res) k = k >>> i_range;
    sum = $signed(x) + k;
    if (sum > 4095) sum = 4095;
    else if (sum < -4096) sum = -4096;
    return sum[12:0];
  endfunction
  task automatic cmp(input string nm, input logic [12:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, e);
    host.rd(a, v);
    cmp("rdata", e, v);
  endtask
  task automatic pulse(ref logic p);
    @(posedge i_clk) #1 p = 1;
    i_sample_vld = 1;
    @(posedge i_clk) #1 p = 0;
    i_sample_vld = 0;
    @(posedge i_clk) #1;
  endtask
  task automatic samp(input axes_s x);
    @(posedge i_clk) #1 i_sample_vld = 1;
    i_sample = x;
    @(posedge i_clk) #1 i_sample_vld = 0;
    n += o_data_vld;
  endtask
  task automatic complete_run();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000 errors++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    #1 i_resetn = 1;
    rchk(ADDR_X_OFS, OFS_RESET);
    rchk(ADDR_Z_OFS, OFS_RESET);
    rchk(ADDR_RATE_PWR, RATE_PWR_RESET);
    rchk(8'h10, 8'h00);
    host.wr(ADDR_RATE_PWR, 8'h0F);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      ofs = (i == 0) ? '{8'h7F, 8'h80, 8'h01} : '{r[7:0], r[15:8], r[23:16]};
      foreach (ofs[j]) host.wr(ADDR_X_OFS + 8'(j), ofs[j]);
      rchk(ADDR_Y_OFS, ofs[1]);
      i_full_res = r[24];
      i_range = r[26:25];
      s = (i == 0) ? '{13'h0FFF, 13'h1000, 13'h0005} : 39'({rnd(), rnd()});
      n = 0;
      samp(s);
      cmp("vld", 1, 13'(n));
      cmp("x", corr(s.x, ofs[0]), o_data.x);
      cmp("y", corr(s.y, ofs[1]), o_data.y);
      cmp("z", corr(s.z, ofs[2]), o_data.z);
    end
    host.wr(ADDR_RATE_PWR, 8'h0E);
    n = 0;
    repeat (4) samp(39'({rnd(), rnd()}));
    cmp("ticks", 2, 13'(n));
    host.wr(ADDR_RATE_PWR, 8'h0F);
    host.wr(ADDR_TAP_AXES, 8'h10);
    cmp("improved", 1, o_tap_improved);
    i_tap_neg = 3'h5;
    pulse(i_tap_filt_hit);
    cmp("sign", 3'h5, o_tap_sign);
    i_tap_neg = 3'h2;
    pulse(i_tap_raw_hit);
    cmp("sign", 3'h5, o_tap_sign);
    host.wr(ADDR_TAP_AXES, 8'h00);
    pulse(i_tap_raw_hit);
    cmp("sign", 3'h2, o_tap_sign);
    rchk(ADDR_EVT_STATUS, 8'h04);
    rchk(ADDR_EVT_STATUS, 8'h04);
    host.rd(ADDR_INT_SRC, v);
    i_tap_raw_hit = 1;
    pulse(i_dtap_hit);
    i_tap_raw_hit = 0;
    pulse(i_ff_hit);
    rchk(ADDR_INT_SRC, 8'h44);
    i_dtap_timing_ok = 1;
    i_tap_raw_hit = 1;
    pulse(i_dtap_hit);
    i_tap_raw_hit = 0;
    rchk(ADDR_INT_SRC, 8'h60);
    rchk(ADDR_INT_SRC, 8'h00);
    {i_link, i_auto_sleep, i_sleep} = 3'h7;
    pulse(i_inact_hit);
    @(posedge i_clk) #1;
    cmp("asleep", 1, o_asleep);
    cmp("rate", SLEEP_RATE, o_active_rate);
    cmp("arm", 2'h2, {o_act_armed, o_inact_armed});
    rchk(ADDR_EVT_STATUS, 8'h0C);
    rchk(ADDR_INT_SRC, 8'h08);
    pulse(i_act_hit);
    @(posedge i_clk) #1;
    cmp("asleep", 0, o_asleep);
    cmp("rate", 4'hF, o_active_rate);
    cmp("arm", 2'h1, {o_act_armed, o_inact_armed});
    pulse(i_inact_hit);
    @(posedge i_clk) #1;
    cmp("asleep", 0, o_asleep);
    host.rd(ADDR_INT_SRC, v);
    cmp("act_src", 1, v[ACT_SRC_BIT]);
    complete_run();
  end
endmodule
